// [verilog/bfp_pkg.sv]
package bfp_pkg;
    // Clock rate in kHz and derived timing
    localparam int CLK_KHZ         = 20000;
    // Hiccup wait in microseconds (1.28 ms)
    localparam int HICCUP_US       = 1280;
    localparam int HICCUP_CYC      = (HICCUP_US * CLK_KHZ) / 1000;
    // Over-voltage deglitch in microseconds
    localparam int OV_DEGLITCH_US  = 20;
    localparam int OV_DEGLITCH_CYC = (OV_DEGLITCH_US * CLK_KHZ) / 1000;
    // Overcurrent counting figures
    localparam int OC_QUIET_CYCLES = 32;
    localparam int OC_TRIP_COUNT   = 5;
    // Controller states
    typedef enum logic [2:0] {
        BFP_OFF     = 3'b000,
        BFP_WAIT_SS = 3'b001,
        BFP_RUN     = 3'b010,
        BFP_HIC_LS  = 3'b011,
        BFP_HIC_IDL = 3'b100
    } bfp_state_t;
endpackage

// [verilog/bfp_sync_if.sv]
`timescale 1ns/10ps
// Carries synchronised comparator levels to the controller
interface bfp_sync_if;
    logic oc;       // Overcurrent
    logic neg_sw;   // Phase node above +100 mV
    logic zero_i;   // Inductor current at zero
    logic ss_gt_fb; // Soft-start above feedback
    logic prebias;  // Output above nominal
    logic fb_hi94;  // Feedback above 94 %
    logic fb_lo91;  // Feedback below 91 %
    logic ov117;    // Feedback above 117 %
    logic ov_lo115; // Feedback below 115 %
    logic ss_564;   // Soft-start above 564 mV
    logic low_det;  // Output low detect
    logic therm;    // Thermal shutdown
    logic enable;   // Enable level
    modport src (output oc, neg_sw, zero_i, ss_gt_fb, prebias, fb_hi94,
                  fb_lo91, ov117, ov_lo115, ss_564, low_det, therm, enable);
    modport dst (input oc, neg_sw, zero_i, ss_gt_fb, prebias, fb_hi94,
                 fb_lo91, ov117, ov_lo115, ss_564, low_det, therm, enable);
endinterface

// [verilog/bfp_sync.sv]
`timescale 1ns/10ps
// Three-stage synchroniser bank; output changes when stages two and three agree
module bfp_sync #(
    parameter int W = 13
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    // Refuse an empty bank
    initial begin
        if (W < 1) begin
            $error("bfp_sync: width must be positive");
        end
    end
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            logic s1_reg;  // First stage, read only by second
            logic s2_reg;  // Second stage
            logic s3_reg;  // Third stage
            logic out_reg; // Qualified level
            // Shift chain and agreement check
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg <= i_async[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign o_sync[g] = out_reg;
        end
    endgenerate
endmodule

// [verilog/bfp_cycle_det.sv]
`timescale 1ns/10ps
// Turns the switching-cycle clock pin into a one-cycle start pulse
module bfp_cycle_det (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_pwm_clk,
    output logic      o_cycle_start
);
    logic s1_reg;   // First stage, read only by second
    logic s2_reg;   // Second stage
    logic s3_reg;   // Third stage
    logic lvl_reg;  // Qualified level
    logic lvl_d_reg; // Delayed level for edge detect
    // Synchronise and qualify
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            lvl_reg   <= 1'b0;
            lvl_d_reg <= 1'b0;
        end else begin
            s1_reg    <= i_pwm_clk;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            lvl_d_reg <= lvl_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end
    // Rising edge marks a new switching cycle
    assign o_cycle_start = lvl_reg & ~lvl_d_reg;
endmodule

// [verilog/bfp_top.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Overcurrent blanks high side for rest of cycle
// - Count events; clear after 32 quiet cycles
// - Five counted events enter hiccup
// - Hiccup waits 1.28 ms then restarts
// - Hiccup entry: high side off, low on
// - Hiccup: low side off once current reaches zero
// - Hiccup discharges the soft-start capacitor
// - Thermal fault holds both gates off
// - Thermal fault forces supply_ok low
// - Negative limit only during output overvoltage
// - Negative limit: low side off above 100 mV in BFP_RUN
// - Output-low detect affects only supply_ok
// - Supply_ok up above 94%, down below 91%
// - Overvoltage 117% drops flag after 20 us
// - No switching until soft-start exceeds feedback
// - No switching when output pre-biased high
// - Dead time keeps gates never both on
// - Fault conditions pull supply_ok low
// - Discharge soft-start on enable, lockout, thermal
// - Supply_ok low until soft-start above 564 mV
module bfp_top
    import bfp_pkg::*;
#(
    parameter int HICCUP_CYCLES = bfp_pkg::HICCUP_CYC,
    parameter int DEAD_CYCLES   = 2
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Supply and enable
    input  wire logic i_uvlo,
    input  wire logic i_enable,
    // Switching cycle and modulator
    input  wire logic i_pwm_clk,
    input  wire logic i_pwm_hs_req,
    // Comparator results
    input  wire logic i_oc_det,
    input  wire logic i_phase_node_pos,
    input  wire logic i_zero_current,
    input  wire logic i_ss_above_feedback,
    input  wire logic i_prebias_high,
    input  wire logic i_feedback_input_94,
    input  wire logic i_feedback_input_91,
    input  wire logic i_output_high_detect,
    input  wire logic i_feedback_input_115,
    input  wire logic i_ss_above_564mv,
    input  wire logic i_output_low_detect,
    input  wire logic i_thermal_fault,
    // Gate commands and status
    output logic      o_hs_gate_en,
    output logic      o_ls_gate_en,
    output logic      o_supply_ok_flag,
    output logic      o_supply_ok_oe_n,
    output logic      o_ss_discharge,
    output logic      o_hiccup,
    output logic      o_ilim_neg_en
);
    import bfp_pkg::*;

    // Refuse counts that the logic cannot serve
    initial begin
        if (HICCUP_CYCLES < 1 || DEAD_CYCLES < 1 || DEAD_CYCLES > 15) begin
            $error("bfp_top: bad timing parameter");
        end
    end

    localparam int HW = $clog2(HICCUP_CYCLES + 1);
    localparam int GW = $clog2(OV_DEGLITCH_CYC + 1);
    localparam logic [HW-1:0] HIC_LAST = HW'(HICCUP_CYCLES - 1);
    localparam logic [GW-1:0] OVG_LAST = GW'(OV_DEGLITCH_CYC - 1);
    localparam logic [5:0]    QUIET_LAST = 6'(OC_QUIET_CYCLES - 1);
    localparam logic [2:0]    TRIP_LAST  = 3'(OC_TRIP_COUNT - 1);
    localparam logic [3:0]    DEAD_LAST  = 4'(DEAD_CYCLES - 1);

    // Synchronised comparator bundle
    bfp_sync_if sif ();
    logic [12:0] raw_in;  // Raw comparator levels
    logic [12:0] syn_out; // Qualified levels
    logic        cycle_start; // New switching cycle pulse

    assign raw_in = {i_oc_det, i_phase_node_pos, i_zero_current,
                     i_ss_above_feedback, i_prebias_high,
                     i_feedback_input_94, i_feedback_input_91,
                     i_output_high_detect, i_feedback_input_115,
                     i_ss_above_564mv, i_output_low_detect,
                     i_thermal_fault, i_enable};

    // Comparator synchronisers
    bfp_sync #(.W(13)) u_sync (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (raw_in),
        .o_sync  (syn_out)
    );

    assign sif.oc       = syn_out[12];
    assign sif.neg_sw   = syn_out[11];
    assign sif.zero_i   = syn_out[10];
    assign sif.ss_gt_fb = syn_out[9];
    assign sif.prebias  = syn_out[8];
    assign sif.fb_hi94  = syn_out[7];
    assign sif.fb_lo91  = syn_out[6];
    assign sif.ov117    = syn_out[5];
    assign sif.ov_lo115 = syn_out[4];
    assign sif.ss_564   = syn_out[3];
    assign sif.low_det  = syn_out[2];
    assign sif.therm    = syn_out[1];
    assign sif.enable   = syn_out[0];

    // Switching-cycle edge detector
    bfp_cycle_det u_cyc (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_pwm_clk     (i_pwm_clk),
        .o_cycle_start (cycle_start)
    );

    // Undervoltage lockout sampled like any pin
    logic uvlo_s1_reg;  // First stage
    logic uvlo_s2_reg;  // Second stage
    logic uvlo_s3_reg;  // Third stage
    logic uvlo_reg;     // Qualified lockout
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            uvlo_s1_reg <= 1'b1;
            uvlo_s2_reg <= 1'b1;
            uvlo_s3_reg <= 1'b1;
            uvlo_reg    <= 1'b1;
        end else begin
            uvlo_s1_reg <= i_uvlo;
            uvlo_s2_reg <= uvlo_s1_reg;
            uvlo_s3_reg <= uvlo_s2_reg;
            if (uvlo_s2_reg == uvlo_s3_reg) begin
                uvlo_reg <= uvlo_s3_reg;
            end
        end
    end

    // Global stop conditions
    logic halt;   // Any condition that stops the controller
    logic en_d_reg; // Previous enable for cycling detect
    assign halt = uvlo_reg | sif.therm | ~sif.enable;

    // Controller state
    bfp_state_t state_reg;
    bfp_state_t state_next;
    logic [2:0]    oc_cnt_reg;    // Overcurrent event count
    logic [5:0]    quiet_reg;     // Event-free cycle count
    logic          oc_seen_reg;   // Event in current cycle
    logic [HW-1:0] hic_cnt_reg;   // Hiccup wait timer
    logic          hs_blank_reg;  // High side blanked this cycle
    logic          oc_rise;       // New overcurrent event
    logic          oc_d_reg;      // Delayed overcurrent level
    logic          trip;          // Hiccup trigger
    logic          hic_done;      // Hiccup wait expired
    logic          hs_reg;        // High-side command
    logic          ls_reg;        // Low-side command

    assign oc_rise  = sif.oc & ~oc_d_reg;
    assign trip     = oc_rise & (oc_cnt_reg == TRIP_LAST);
    assign hic_done = (hic_cnt_reg == HIC_LAST);

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BFP_OFF: begin
                if (!halt) begin
                    state_next = BFP_WAIT_SS;
                end
            end
            BFP_WAIT_SS: begin
                if (sif.ss_gt_fb && !sif.prebias) begin
                    state_next = BFP_RUN;
                end
            end
            BFP_RUN: begin
                if (trip) begin
                    state_next = BFP_HIC_LS;
                end
            end
            BFP_HIC_LS: begin
                if (sif.zero_i && ls_reg) begin
                    state_next = BFP_HIC_IDL;
                end
            end
            BFP_HIC_IDL: begin
                if (hic_done) begin
                    state_next = BFP_OFF;
                end
            end
            default: begin
                state_next = BFP_OFF;
            end
        endcase
        if (halt) begin
            state_next = BFP_OFF;
        end
    end

    // State register and overcurrent bookkeeping
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= BFP_OFF;
            oc_d_reg  <= 1'b0;
            en_d_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            oc_d_reg  <= sif.oc;
            en_d_reg  <= sif.enable;
        end
    end

    // Event counter and quiet-cycle counter
    always_ff @(posedge i_clk) begin
        if (i_srst || state_reg != BFP_RUN || trip) begin
            oc_cnt_reg  <= 3'h0;
            quiet_reg   <= 6'h00;
            oc_seen_reg <= 1'b0;
        end else begin
            if (oc_rise) begin
                oc_cnt_reg <= oc_cnt_reg + 3'h1;
            end
            if (cycle_start) begin
                oc_seen_reg <= oc_rise;
                if (oc_seen_reg || oc_rise) begin
                    quiet_reg <= 6'h00;
                end else if (quiet_reg == QUIET_LAST) begin
                    quiet_reg  <= 6'h00;
                    if (!oc_rise) begin
                        oc_cnt_reg <= 3'h0;
                    end
                end else begin
                    quiet_reg <= quiet_reg + 6'h01;
                end
            end else if (oc_rise) begin
                oc_seen_reg <= 1'b1;
            end
        end
    end

    // Cycle-by-cycle high-side blanking
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hs_blank_reg <= 1'b0;
        end else if (sif.oc) begin
            hs_blank_reg <= 1'b1;
        end else if (cycle_start) begin
            hs_blank_reg <= 1'b0;
        end
    end

    // Hiccup wait timer on the fixed system clock
    always_ff @(posedge i_clk) begin
        if (i_srst || state_reg != BFP_HIC_IDL) begin
            hic_cnt_reg <= '0;
        end else if (!hic_done) begin
            hic_cnt_reg <= hic_cnt_reg + HW'(1);
        end
    end

    // Overvoltage deglitch and hysteresis
    logic [GW-1:0] ovg_cnt_reg; // Deglitch timer
    logic          ov_reg;      // Qualified overvoltage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ovg_cnt_reg <= '0;
            ov_reg      <= 1'b0;
        end else if (sif.ov117 && !ov_reg) begin
            if (ovg_cnt_reg == OVG_LAST) begin
                ov_reg <= 1'b1;
            end else begin
                ovg_cnt_reg <= ovg_cnt_reg + GW'(1);
            end
        end else begin
            ovg_cnt_reg <= '0;
            if (sif.ov_lo115) begin
                ov_reg <= 1'b0;
            end
        end
    end

    // Regulation window with 94/91 hysteresis
    logic reg_ok_reg; // Output in regulation
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            reg_ok_reg <= 1'b0;
        end else if (sif.fb_lo91) begin
            reg_ok_reg <= 1'b0;
        end else if (sif.fb_hi94) begin
            reg_ok_reg <= 1'b1;
        end
    end

    // Supply-ok decision
    logic ok_next; // Flag value to register
    logic ok_reg;  // Registered flag
    assign ok_next = reg_ok_reg & ~ov_reg & ~sif.low_det
                   & ~sif.therm & ~uvlo_reg
                   & ~hs_blank_reg & sif.ss_564
                   & (state_reg == BFP_RUN);
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ok_reg <= 1'b0;
        end else begin
            ok_reg <= ok_next;
        end
    end

    // Raw gate requests before dead time
    logic hs_want; // High side wanted
    logic ls_want; // Low side wanted
    logic neg_cut; // Negative limit cut
    assign neg_cut = ov_reg & sif.neg_sw;
    assign hs_want = (state_reg == BFP_RUN) & i_pwm_hs_req
                   & ~hs_blank_reg & ~sif.oc;
    assign ls_want = ((state_reg == BFP_RUN) & ~i_pwm_hs_req & ~neg_cut)
                   | (state_reg == BFP_HIC_LS);

    // Dead time: a gate turns on only after both were off long enough
    logic [3:0] dead_reg; // Cycles both gates off
    always_ff @(posedge i_clk) begin
        if (i_srst || halt) begin
            hs_reg   <= 1'b0;
            ls_reg   <= 1'b0;
            dead_reg <= 4'h0;
        end else begin
            hs_reg <= hs_reg & hs_want;
            ls_reg <= ls_reg & ls_want;
            if (hs_reg || ls_reg) begin
                dead_reg <= 4'h0;
            end else if (dead_reg != DEAD_LAST) begin
                dead_reg <= dead_reg + 4'h1;
            end else if (hs_want) begin
                hs_reg <= 1'b1;
            end else if (ls_want) begin
                ls_reg <= 1'b1;
            end
        end
    end

    // Outputs
    assign o_hs_gate_en     = hs_reg;
    assign o_ls_gate_en     = ls_reg;
    assign o_supply_ok_flag = ok_reg;
    assign o_supply_ok_oe_n = ok_reg;  // Low while pulling the pin low
    assign o_ss_discharge   = (state_reg == BFP_OFF)
                            | (state_reg == BFP_HIC_LS)
                            | (state_reg == BFP_HIC_IDL)
                            | (en_d_reg & ~sif.enable);
    assign o_hiccup         = (state_reg == BFP_HIC_LS)
                            | (state_reg == BFP_HIC_IDL);
    assign o_ilim_neg_en    = ov_reg;
endmodule

// [sim/bfp_stage_model.sv]
`timescale 1ns/10ps
// Power stage stand-in: cycle clock, modulator request, coil current
module bfp_stage_model #(
    parameter int PERIOD = 40 // Clocks per switching cycle
) (
    // Clock
    input  wire logic i_clk,
    // Gate commands from the controller
    input  wire logic i_hs_on,
    input  wire logic i_ls_on,
    // Stage outputs
    output logic      o_pwm_clk,
    output logic      o_hs_req,
    output logic      o_zero_i
);
    int phase = 0; // Position inside the cycle
    int cur   = 0; // Coil current in steps
    // Quiet outputs at time zero
    initial begin
        o_pwm_clk = 1'b0;
        o_hs_req  = 1'b0;
        o_zero_i  = 1'b1;
    end
    // Move on the falling edge, away from the sampling edge
    always @(negedge i_clk) begin
        phase = (phase + 1) % PERIOD;
        o_pwm_clk <= (phase < PERIOD / 4);
        o_hs_req  <= (phase < PERIOD / 2);
        // Current rises with high side, drains only through low side
        if (i_hs_on === 1'b1 && cur < 60)
            cur = cur + 2;
        else if (i_ls_on === 1'b1 && cur > 0)
            cur = cur - 1;
        o_zero_i <= (cur == 0);
    end
endmodule

// [sim/bfp_top_asserts.sv]
`timescale 1ns/10ps
// Concurrent checks on the supervisor's ports
module bfp_top_asserts
    import bfp_pkg::*;
#(
    parameter int HICCUP_CYCLES = bfp_pkg::HICCUP_CYC,
    parameter int DEAD_CYCLES   = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Watched inputs
    input wire logic i_uvlo,
    input wire logic i_oc_det,
    input wire logic i_phase_node_pos,
    input wire logic i_output_high_detect,
    input wire logic i_ss_above_564mv,
    input wire logic i_output_low_detect,
    input wire logic i_thermal_fault,
    // Watched outputs
    input wire logic o_hs_gate_en,
    input wire logic o_ls_gate_en,
    input wire logic o_supply_ok_flag,
    input wire logic o_ss_discharge,
    input wire logic o_hiccup,
    input wire logic o_ilim_neg_en
);
    int hic_cnt; // Hiccup clocks since low side was last on
    int ov_cnt;  // Consecutive clocks of the over-voltage input
    // Idle hiccup time and over-voltage persistence
    always_ff @(posedge i_clk) begin
        if (i_srst || !o_hiccup || o_ls_gate_en)
            hic_cnt <= 0;
        else
            hic_cnt <= hic_cnt + 1;
        if (i_srst || !i_output_high_detect)
            ov_cnt <= 0;
        else if (ov_cnt < 100000)
            ov_cnt <= ov_cnt + 1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Overcurrent held long enough to pass the synchroniser
    sequence s_oc_held;
        i_oc_det [*7];
    endsequence
    // Entry into hiccup
    sequence s_hic_start;
        $rose(o_hiccup);
    endsequence
    chk_gate_overlap: assert property (
        !(o_hs_gate_en && o_ls_gate_en)) else $error("gates both on");
    chk_oc_blank: assert property (
        s_oc_held |-> !o_hs_gate_en) else $error("high side not blanked");
    chk_hic_ls_on: assert property (
        s_hic_start |-> ##[1:8] o_ls_gate_en) else $error("no low side");
    chk_hic_hs_off: assert property (
        o_hiccup && $past(o_hiccup) |-> !o_hs_gate_en)
        else $error("high side on in hiccup");
    chk_hic_discharge: assert property (
        o_hiccup |-> o_ss_discharge) else $error("no discharge in hiccup");
    chk_hic_wait: assert property (
        $fell(o_hiccup) |-> hic_cnt >= HICCUP_CYCLES - 2
            && hic_cnt <= HICCUP_CYCLES + 14) else $error("hiccup length");
    chk_therm_off: assert property (
        i_thermal_fault [*8] |-> !o_hs_gate_en && !o_ls_gate_en
            && !o_supply_ok_flag) else $error("thermal fault ignored");
    chk_ov_deglitch: assert property (
        $rose(o_ilim_neg_en) |-> ov_cnt >= OV_DEGLITCH_CYC
            && ov_cnt <= OV_DEGLITCH_CYC + 8) else $error("ov deglitch");
    chk_neg_cut: assert property (
        (o_ilim_neg_en && i_phase_node_pos) [*7] |-> !o_ls_gate_en)
        else $error("low side not cut");
    chk_low_flag: assert property (
        i_output_low_detect [*7] |-> !o_supply_ok_flag)
        else $error("flag high with output low");
    chk_uvlo_state: assert property (
        i_uvlo [*7] |-> o_ss_discharge && !o_supply_ok_flag)
        else $error("lockout ignored");
    chk_ss_flag: assert property (
        (!i_ss_above_564mv) [*7] |-> !o_supply_ok_flag)
        else $error("flag high before soft-start");
endmodule
bind bfp_top bfp_top_asserts #(
    .HICCUP_CYCLES(HICCUP_CYCLES),
    .DEAD_CYCLES  (DEAD_CYCLES)
) bfp_top_asserts_inst (
    .i_clk, .i_srst, .i_uvlo, .i_oc_det, .i_phase_node_pos,
    .i_output_high_detect, .i_ss_above_564mv, .i_output_low_detect,
    .i_thermal_fault, .o_hs_gate_en, .o_ls_gate_en, .o_supply_ok_flag,
    .o_ss_discharge, .o_hiccup, .o_ilim_neg_en
);

// [sim/tb_bfp_top.sv]
`timescale 1ns/10ps
// Self-checking bench for the fault and start-up supervisor
module tb_bfp_top;
    import bfp_pkg::*;
    localparam int HIC = 64; // Short hiccup wait
    localparam int PER = 40; // Clocks per switching cycle
    // Bench-driven inputs
    logic i_clk = 0, i_srst = 1, i_uvlo = 1, i_enable = 0;
    logic i_oc_det = 0, i_phase_node_pos = 0, i_ss_above_feedback = 0;
    logic i_prebias_high = 1, i_feedback_input_94 = 1;
    logic i_feedback_input_91 = 0, i_output_high_detect = 0;
    logic i_feedback_input_115 = 1, i_ss_above_564mv = 0;
    logic i_output_low_detect = 0, i_thermal_fault = 0;
    // Stage model outputs
    logic i_pwm_clk, i_pwm_hs_req, i_zero_current;
    // Design outputs
    logic o_hs_gate_en, o_ls_gate_en, o_supply_ok_flag, o_supply_ok_oe_n;
    logic o_ss_discharge, o_hiccup, o_ilim_neg_en;
    int n_mismatch = 0;   // Failed compares
    int total_checks = 0; // All compares
    int cyc = 0;          // Clock count for the hang guard
    logic hs_seen = 0;    // High side was on since last clear
    logic ls_seen = 0;    // Low side was on since last clear
    bfp_top #(.HICCUP_CYCLES(HIC)) bfp_top_inst (
        .i_clk, .i_srst, .i_uvlo, .i_enable, .i_pwm_clk, .i_pwm_hs_req,
        .i_oc_det, .i_phase_node_pos, .i_zero_current,
        .i_ss_above_feedback, .i_prebias_high, .i_feedback_input_94,
        .i_feedback_input_91, .i_output_high_detect,
        .i_feedback_input_115, .i_ss_above_564mv, .i_output_low_detect,
        .i_thermal_fault, .o_hs_gate_en, .o_ls_gate_en, .o_supply_ok_flag,
        .o_supply_ok_oe_n, .o_ss_discharge, .o_hiccup, .o_ilim_neg_en);
    bfp_stage_model #(.PERIOD(PER)) bfp_stage_model_inst (
        .i_clk, .i_hs_on(o_hs_gate_en), .i_ls_on(o_ls_gate_en),
        .o_pwm_clk(i_pwm_clk), .o_hs_req(i_pwm_hs_req),
        .o_zero_i(i_zero_current));
    // Clock, 50 ns period
    initial forever #25 i_clk = ~i_clk;
    // Gate activity marks and hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (o_hs_gate_en === 1'b1)
            hs_seen = 1'b1;
        if (o_ls_gate_en === 1'b1)
            ls_seen = 1'b1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    // Compare one seen bit with its expected value
    task automatic check(input string name, input logic seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Wait n falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Watch two switching cycles for gate activity
    task automatic watch(input string name, input logic hs, ls);
        tick(10);
        hs_seen = 1'b0;
        ls_seen = 1'b0;
        tick(2 * PER);
        check({name, "_hs"}, hs_seen, hs);
        check({name, "_ls"}, ls_seen, ls);
    endtask
    // Overcurrent pulse early in a switching cycle
    task automatic oc_event();
        @(posedge i_pwm_clk);
        tick(2);
        ls_seen = 1'b0;
        i_oc_det = 1'b1;
        tick(8);
        i_oc_det = 1'b0;
    endtask
    // One line as each test ends
    task automatic fin(input string name);
        $display("test %s finished", name);
    endtask
    // Counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        tick(6);
        check("ss_dis_rst", o_ss_discharge, 1'b1);
        i_srst = 1'b0;
        i_uvlo = 1'b0;
        i_enable = 1'b1;
        i_ss_above_feedback = 1'b1;
        watch("prebias", 1'b0, 1'b0);
        i_prebias_high = 1'b0;
        i_ss_above_feedback = 1'b0;
        watch("ss_low", 1'b0, 1'b0);
        i_ss_above_feedback = 1'b1;
        watch("ss_high", 1'b1, 1'b1);
        check("flag_ss", o_supply_ok_flag, 1'b0);
        check("ss_run", o_ss_discharge, 1'b0);
        fin("startup");
        i_ss_above_564mv = 1'b1;
        tick(20);
        check("flag_up", o_supply_ok_flag, 1'b1);
        check("oe_n", o_supply_ok_oe_n, 1'b1);
        i_feedback_input_94 = 1'b0;
        tick(20);
        check("flag_hyst", o_supply_ok_flag, 1'b1);
        i_feedback_input_91 = 1'b1;
        tick(20);
        check("flag_91", o_supply_ok_flag, 1'b0);
        check("oe_n_low", o_supply_ok_oe_n, 1'b0);
        i_feedback_input_91 = 1'b0;
        tick(20);
        check("flag_mid", o_supply_ok_flag, 1'b0);
        i_feedback_input_94 = 1'b1;
        tick(20);
        check("flag_94", o_supply_ok_flag, 1'b1);
        fin("regulation");
        i_output_low_detect = 1'b1;
        watch("low", 1'b1, 1'b1);
        check("flag_low", o_supply_ok_flag, 1'b0);
        i_output_low_detect = 1'b0;
        fin("low_detect");
        i_output_high_detect = 1'b1;
        i_feedback_input_115 = 1'b0;
        tick(300);
        check("ov_early", o_supply_ok_flag, 1'b1);
        check("neg_early", o_ilim_neg_en, 1'b0);
        tick(120);
        check("ov_flag", o_supply_ok_flag, 1'b0);
        check("neg_on", o_ilim_neg_en, 1'b1);
        i_phase_node_pos = 1'b1;
        watch("neg", 1'b1, 1'b0);
        i_phase_node_pos = 1'b0;
        i_output_high_detect = 1'b0;
        i_feedback_input_115 = 1'b1;
        tick(20);
        check("neg_off", o_ilim_neg_en, 1'b0);
        check("ov_clear", o_supply_ok_flag, 1'b1);
        fin("overvoltage");
        oc_event();
        tick(4);
        check("hs_blank", o_hs_gate_en, 1'b0);
        @(posedge i_pwm_clk);
        tick(12);
        check("hs_resume", o_hs_gate_en, 1'b1);
        repeat (3) oc_event();
        tick(34 * PER);
        repeat (4) oc_event();
        check("hic_quiet", o_hiccup, 1'b0);
        oc_event();
        tick(10);
        check("hic_on", o_hiccup, 1'b1);
        check("hic_hs", o_hs_gate_en, 1'b0);
        check("hic_ls", ls_seen, 1'b1);
        tick(20);
        check("hic_idle_ls", o_ls_gate_en, 1'b0);
        check("hic_idle_hs", o_hs_gate_en, 1'b0);
        check("hic_ss", o_ss_discharge, 1'b1);
        check("hic_wait", o_hiccup, 1'b1);
        check("hic_flag", o_supply_ok_flag, 1'b0);
        tick(100);
        check("hic_end", o_hiccup, 1'b0);
        watch("restart", 1'b1, 1'b1);
        repeat (4) oc_event();
        check("hic_fresh", o_hiccup, 1'b0);
        fin("overcurrent");
        i_thermal_fault = 1'b1;
        tick(8);
        check("th_flag", o_supply_ok_flag, 1'b0);
        check("th_ss", o_ss_discharge, 1'b1);
        watch("therm", 1'b0, 1'b0);
        i_thermal_fault = 1'b0;
        watch("th_off", 1'b1, 1'b1);
        fin("thermal");
        i_uvlo = 1'b1;
        tick(8);
        check("uv_ss", o_ss_discharge, 1'b1);
        check("uv_flag", o_supply_ok_flag, 1'b0);
        i_uvlo = 1'b0;
        tick(100);
        i_enable = 1'b0;
        tick(8);
        check("en_ss", o_ss_discharge, 1'b1);
        watch("en_off", 1'b0, 1'b0);
        fin("lockout");
        test_done();
    end
endmodule
